/* core/hif_pkg.sv */
// shared constants and types for the gate a20 and shutdown block
package hif_pkg;

  // host commands recognised by the fast gate logic
  localparam logic [7:0]  CMD_GATE      = 8'hD1;
  localparam logic [7:0]  CMD_TRAIL     = 8'hFF;
  localparam int unsigned GATE_BIT      = 1;
  localparam logic [1:0]  CHAN1         = 2'h1;
  localparam logic        GATE_RST      = 1'b1;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL0     = 12'h000;
  localparam logic [11:0] OFS_CTRL2     = 12'h004;
  localparam logic [11:0] OFS_DATA1     = 12'h008;
  localparam logic [11:0] OFS_IRQ_STS   = 12'h00C;
  localparam logic [11:0] OFS_IRQ_MSK   = 12'h010;

  // host_ctrl_reg_zero fields
  localparam int unsigned C0_FAST_GATE  = 0;
  localparam int unsigned C0_HW_SD_EN   = 1;
  localparam int unsigned C0_SOFT_SD    = 2;
  localparam int unsigned C0_SOFT_RST   = 3;
  localparam logic [3:0]  CTRL0_RST     = 4'h0;

  // host_ctrl_reg_two fields (read only)
  localparam int unsigned C2_GATE       = 0;
  localparam int unsigned C2_FULL       = 1;
  localparam int unsigned C2_SD         = 2;
  localparam int unsigned C2_HW_SD      = 3;
  localparam int unsigned C2_PD         = 4;
  localparam int unsigned C2_LRST       = 5;

  // interrupt status and mask fields
  localparam int unsigned EV_FULL       = 0;
  localparam int unsigned EV_SD         = 1;
  localparam int unsigned EV_PD_RISE    = 2;
  localparam int unsigned EV_LRST       = 3;
  localparam int unsigned EV_W          = 4;
  localparam logic [3:0]  MSK_RST       = 4'h0;

  typedef enum logic [1:0] {
    HIF_IDLE  = 2'b00,
    HIF_WAIT  = 2'b01,
    HIF_AFTER = 2'b11
  } hif_gate_state_type;

endpackage : hif_pkg

/* core/hif_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hif_sync
  import hif_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hif_sync_state_type;

  hif_sync_state_type q, d;

  always_comb begin
    d = q;
    if (ce) begin
      d.s1 = async_in;
      d.s2 = q.s1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;

endmodule : hif_sync

/* core/hif_gate.sv */
// fast gate a20 command decoder for channel 1 host writes
`timescale 1ns/1ps
module hif_gate
  import hif_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       fast_en,
  input  wire logic       link_rst,
  input  wire logic       seq_clr,
  input  wire logic       wr_stb,
  input  wire logic       wr_cmd,
  input  wire logic [7:0] wr_data,
  output logic            gate,
  output logic            set_full
);

  typedef struct packed {
    hif_gate_state_type st;
    logic               gate;
    logic               set_full;
  } hif_gate_reg_type;

  hif_gate_reg_type q, d;
  logic is_gate_cmd;
  logic is_trail_cmd;

  assign is_gate_cmd  = wr_cmd && (wr_data == CMD_GATE);
  assign is_trail_cmd = wr_cmd && (wr_data == CMD_TRAIL);

  always_comb begin
    d = q;
    if (ce) begin
      d.set_full = 1'b0;
      if (link_rst) begin
        d.st   = HIF_IDLE;
        d.gate = GATE_RST;
      end else if (!fast_en) begin
        // slow path: every write goes to firmware, pin parked high [RL1] [RL2]
        d.st       = HIF_IDLE;
        d.gate     = GATE_RST;
        d.set_full = wr_stb;
      end else if (seq_clr) begin
        // sequence is dropped in shutdown, pin level is retained
        d.st = HIF_IDLE;
      end else if (wr_stb) begin
        unique case (q.st)
          HIF_IDLE: begin
            if (is_gate_cmd) begin
              d.st = HIF_WAIT;
            end else begin
              d.set_full = 1'b1;
            end
          end
          HIF_WAIT: begin
            if (!wr_cmd) begin
              d.gate = wr_data[GATE_BIT]; // [RL5]
              d.st   = HIF_AFTER;
            end else if (is_gate_cmd) begin
              d.st = HIF_WAIT; // [RL7]
            end else begin
              d.st       = HIF_IDLE; // [RL7]
              d.set_full = 1'b1;
            end
          end
          HIF_AFTER: begin
            if (is_trail_cmd) begin
              d.st = HIF_IDLE; // [RL6]
            end else if (is_gate_cmd) begin
              d.st = HIF_WAIT;
            end else begin
              d.st       = HIF_IDLE; // [RL6]
              d.set_full = 1'b1;
            end
          end
          default: begin
            d.st = HIF_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{st: HIF_IDLE, gate: GATE_RST, set_full: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign gate     = q.gate;
  assign set_full = q.set_full;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_gate_parked_high: assert property ( // [RL2]
    (ce && !fast_en) |=> gate) else $error("gate not parked high while slow mode");

  a_slow_sets_full: assert property ( // [RL1]
    (ce && !fast_en && !link_rst && wr_stb) |=> set_full)
    else $error("slow mode write did not raise full flag");

  a_data_drives_pin: assert property ( // [RL5]
    (ce && fast_en && !link_rst && !seq_clr && wr_stb && !wr_cmd && q.st == HIF_WAIT)
    |=> (gate == $past(wr_data[GATE_BIT])) && !set_full)
    else $error("data after gate command not on pin");

  a_gate_cmd_quiet: assert property ( // [RL6]
    (ce && fast_en && !link_rst && !seq_clr && wr_stb && is_gate_cmd)
    |=> !set_full && q.st == HIF_WAIT && $stable(gate))
    else $error("gate command raised full flag or moved pin");

  a_trail_quiet: assert property ( // [RL6]
    (ce && fast_en && !link_rst && !seq_clr && wr_stb && is_trail_cmd && q.st == HIF_AFTER)
    |=> !set_full && $stable(gate))
    else $error("trailing command raised full flag");

  a_cancel_flags: assert property ( // [RL7]
    (ce && fast_en && !link_rst && !seq_clr && wr_stb && wr_cmd && !is_gate_cmd
     && q.st == HIF_WAIT) |=> set_full && $stable(gate) && q.st == HIF_IDLE)
    else $error("cancelled sequence mishandled");

  c_turn_off: cover property (fast_en && $fell(gate));
  c_cancel:   cover property (q.st == HIF_WAIT && wr_stb && wr_cmd && !is_gate_cmd && ce);

endmodule : hif_gate

/* core/hif_gate_a20_shutdown.sv */
// gate a20 and host interface shutdown control with apb registers
`timescale 1ns/1ps

// Functional notes
// RL1 - the hardware gate a20 decoder works only while fast_gate_enable is 1.
// RL2 - while fast_gate_enable is 0 the internal gate a20 state is held at 1.
// RL3 - the gate a20 pin level is readable in host_ctrl_reg_two.
// RL4 - only channel 1 host writes reach the gate a20 decoder.
// RL5 - data following command D1 puts its bit 1 on the gate a20 pin.
// RL6 - D1, its data and a trailing FF leave the full flag clear; other commands set it.
// RL7 - a non D1 command after D1 cancels with the full flag set; another D1 restarts.
// RL8 - shutdown comes from the powerdown pin (hardware) or from soft_shutdown_bit.
// RL9 - in shutdown the host interface is held in reset and ignores all but reset and powerdown.
// RL10 - with hw_shutdown_enable set, the powerdown falling edge enters shutdown at once.
// RL11 - the powerdown rising edge does not release a software shutdown.
// RL12 - firmware must leave software standby before powerdown lifts the shutdown.
// RL13 - a powerdown rising edge clears hw_shutdown_enable.
// RL14 - entering hardware shutdown clears soft_shutdown_bit.
// RL15 - link reset clears soft_link_reset_bit, hw_shutdown_enable and soft_shutdown_bit.
// RL16 - in shutdown the link pins go high impedance while reset and powerdown stay live.
// RL17 - cmd_data_select high marks a channel 1 write as a command, low as data.
module hif_gate_a20_shutdown
  import hif_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lclk,
  input  wire logic        lwr_valid,
  input  wire logic [1:0]  lwr_chan,
  input  wire logic        cmd_data_select,
  input  wire logic [7:0]  lwr_data,
  input  wire logic        lrst_n,
  input  wire logic        lpcpd_n,
  output logic             gate_a20_out,
  output logic             gate_a20_oe,
  output logic             pins_hiz,
  output logic             hif_in_reset,
  output logic             irq
);

  typedef struct packed {
    logic              lclk_prev;
    logic              pd_prev;
    logic              lrst_prev;
    logic              fast_gate_enable;
    logic              hw_shutdown_enable;
    logic              soft_shutdown_bit;
    logic              soft_link_reset_bit;
    logic              full;
    logic [7:0]        data1;
    logic [EV_W-1:0]   sts;
    logic [EV_W-1:0]   msk;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              gate_out;
    logic              gate_oe;
    logic              hiz;
    logic              in_rst;
    logic              irq;
  } hif_top_state_type;

  hif_top_state_type q, d;

  logic [14:0]       sync_s;
  logic              lclk_s;
  logic              valid_s;
  logic [1:0]        chan_s;
  logic              cmd_s;
  logic [7:0]        data_s;
  logic              lrst_n_s;
  logic              pd_n_s;
  logic              lrst_act;
  logic              link_rst;
  logic              hw_sd;
  logic              shutdown;
  logic              lclk_fall;
  logic              pd_fall;
  logic              pd_rise;
  logic              chan1_wr;
  logic              apb_setup;
  logic              apb_done;
  logic              wr_en;
  logic              rd_en;
  logic              mapped;
  logic              gate;
  logic              set_full;
  logic [31:0]       rd_mux;
  logic [EV_W-1:0]   ev;

  // all link pins are asynchronous to clk_sys, lclk included
  hif_sync #(.W(15)) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .async_in ({lclk, lwr_valid, lwr_chan, cmd_data_select, lwr_data, lrst_n, lpcpd_n}),
    .sync_out (sync_s)
  );

  assign {lclk_s, valid_s, chan_s, cmd_s, data_s, lrst_n_s, pd_n_s} = sync_s;

  assign lrst_act  = ~lrst_n_s;
  assign link_rst  = lrst_act | q.soft_link_reset_bit;
  assign hw_sd     = q.hw_shutdown_enable & ~pd_n_s; // [RL8] [RL10]
  assign shutdown  = hw_sd | q.soft_shutdown_bit; // [RL8]
  // host drives on the rising edge, so the falling edge sees settled data
  assign lclk_fall = q.lclk_prev & ~lclk_s;
  assign pd_fall   = q.pd_prev & ~pd_n_s;
  // the synchronisers leave reset low, so the powerdown pin seems to rise just after
  // reset; that edge lands while the link reset seen at the same time is still in
  // lrst_prev, so masking with it stops a false rise from being logged
  assign pd_rise   = ~q.pd_prev & pd_n_s & ~q.lrst_prev;
  assign chan1_wr  = lclk_fall & valid_s & (chan_s == CHAN1) & ~shutdown & ~link_rst; // [RL4] [RL9]

  hif_gate u_gate (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .fast_en  (q.fast_gate_enable), // [RL1]
    .link_rst (link_rst),
    .seq_clr  (shutdown), // [RL9]
    .wr_stb   (chan1_wr),
    .wr_cmd   (cmd_s), // [RL17]
    .wr_data  (data_s),
    .gate     (gate),
    .set_full (set_full)
  );

  // apb: setup, one wait cycle, then pready; two cycles of penable per access
  assign apb_setup = psel & penable & ~q.pready;
  assign apb_done  = psel & penable & q.pready;
  assign wr_en     = apb_done & pwrite;
  assign rd_en     = apb_done & ~pwrite;
  assign mapped    = (paddr == OFS_CTRL0) || (paddr == OFS_CTRL2) || (paddr == OFS_DATA1)
                  || (paddr == OFS_IRQ_STS) || (paddr == OFS_IRQ_MSK);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL0: begin
        rd_mux[C0_FAST_GATE] = q.fast_gate_enable;
        rd_mux[C0_HW_SD_EN]  = q.hw_shutdown_enable;
        rd_mux[C0_SOFT_SD]   = q.soft_shutdown_bit;
        rd_mux[C0_SOFT_RST]  = q.soft_link_reset_bit;
      end
      OFS_CTRL2: begin
        rd_mux[C2_GATE]  = q.gate_out; // [RL3]
        rd_mux[C2_FULL]  = q.full;
        rd_mux[C2_SD]    = shutdown;
        rd_mux[C2_HW_SD] = hw_sd;
        rd_mux[C2_PD]    = pd_n_s;
        rd_mux[C2_LRST]  = lrst_act;
      end
      OFS_DATA1:   rd_mux[7:0]      = q.data1;
      OFS_IRQ_STS: rd_mux[EV_W-1:0] = q.sts;
      OFS_IRQ_MSK: rd_mux[EV_W-1:0] = q.msk;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    ev          = '0;
    ev[EV_FULL] = set_full;
    ev[EV_SD]   = shutdown & ~q.hiz;
    ev[EV_PD_RISE] = pd_rise;
    ev[EV_LRST] = lrst_act & ~q.lrst_prev;
  end

  always_comb begin
    d = q;
    if (ce) begin
      d.lclk_prev = lclk_s;
      d.pd_prev   = pd_n_s;
      d.lrst_prev = lrst_act;
      d.pready    = apb_setup;
      d.pslverr   = apb_setup & ~mapped;
      if (apb_setup) begin
        d.prdata = pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_en && paddr == OFS_CTRL0) begin
        d.fast_gate_enable    = pwdata[C0_FAST_GATE];
        d.hw_shutdown_enable  = pwdata[C0_HW_SD_EN];
        d.soft_shutdown_bit   = pwdata[C0_SOFT_SD];
        d.soft_link_reset_bit = pwdata[C0_SOFT_RST];
      end
      if (wr_en && paddr == OFS_IRQ_MSK) begin
        d.msk = pwdata[EV_W-1:0];
      end
      if (chan1_wr) begin
        d.data1 = data_s;
      end
      // hardware set beats the read clear
      if (rd_en && paddr == OFS_DATA1) begin
        d.full = 1'b0;
      end
      if (set_full) begin
        d.full = 1'b1; // [RL6]
      end
      // clear first, then or in the events, so an event in the read cycle is kept
      if (rd_en && paddr == OFS_IRQ_STS) begin
        d.sts = '0;
      end
      d.sts = d.sts | ev;
      if (pd_rise) begin
        // only the hardware enable drops here; a software shutdown stays
        d.hw_shutdown_enable = 1'b0; // [RL11] [RL13]
      end
      if (hw_sd) begin
        d.soft_shutdown_bit = 1'b0; // [RL14]
      end
      // soft link reset outranks shutdown, so it clears both shutdown bits
      if (q.soft_link_reset_bit) begin
        d.hw_shutdown_enable = 1'b0;
        d.soft_shutdown_bit  = 1'b0;
        d.full               = 1'b0;
      end
      if (lrst_act) begin
        d.soft_link_reset_bit = 1'b0; // [RL15]
        d.hw_shutdown_enable  = 1'b0; // [RL15]
        d.soft_shutdown_bit   = 1'b0; // [RL15]
        d.full                = 1'b0;
      end
      d.hiz      = shutdown; // [RL16]
      d.in_rst   = shutdown | link_rst; // [RL9]
      d.gate_out = gate;
      d.gate_oe  = d.fast_gate_enable & ~shutdown; // [RL16]
      d.irq      = |(d.sts & d.msk);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q                     <= '0;
      q.fast_gate_enable    <= CTRL0_RST[C0_FAST_GATE];
      q.hw_shutdown_enable  <= CTRL0_RST[C0_HW_SD_EN];
      q.soft_shutdown_bit   <= CTRL0_RST[C0_SOFT_SD];
      q.soft_link_reset_bit <= CTRL0_RST[C0_SOFT_RST];
      q.msk                 <= MSK_RST;
      q.gate_out            <= GATE_RST;
      q.in_rst              <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign gate_a20_out = q.gate_out;
  assign gate_a20_oe  = q.gate_oe;
  assign pins_hiz     = q.hiz;
  assign hif_in_reset = q.in_rst;
  assign irq          = q.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_status_shows_pin: assert property ( // [RL3]
    (ce && apb_setup && !pwrite && paddr == OFS_CTRL2)
    |=> prdata[C2_GATE] == $past(gate_a20_out)) else $error("status bit differs from pin");

  a_hw_sd_entry: assert property ( // [RL10]
    (ce && q.hw_shutdown_enable && pd_fall && !link_rst) |=> pins_hiz && !gate_a20_oe)
    else $error("hardware shutdown not entered on powerdown fall");

  a_rise_clears_en: assert property ( // [RL13]
    (ce && pd_rise) |=> !q.hw_shutdown_enable) else $error("powerdown rise kept enable");

  a_hw_clears_soft: assert property ( // [RL14]
    (ce && hw_sd) |=> !q.soft_shutdown_bit) else $error("soft shutdown kept in hardware shutdown");

  a_soft_sd_kept: assert property ( // [RL11]
    (ce && q.soft_shutdown_bit && pd_rise && !link_rst && !hw_sd && !wr_en)
    |=> q.soft_shutdown_bit && pins_hiz) else $error("powerdown rise released soft shutdown");

  a_lrst_clears: assert property ( // [RL15]
    (ce && lrst_act) |=> !q.soft_link_reset_bit && !q.hw_shutdown_enable
    && !q.soft_shutdown_bit) else $error("link reset left control bits set");

  a_sd_in_reset: assert property ( // [RL9]
    (ce && shutdown) |=> hif_in_reset && pins_hiz) else $error("shutdown not holding reset");

  a_sd_blocks_writes: assert property ( // [RL9]
    (ce && shutdown) |=> !set_full) else $error("link write taken in shutdown");

  a_sd_oe_off: assert property ( // [RL16]
    (ce && shutdown) |=> !gate_a20_oe) else $error("gate pin driven in shutdown");

  a_sd_keeps_full: assert property ( // [RL9]
    (ce && shutdown && !link_rst && !rd_en && !set_full) |=> $stable(q.full))
    else $error("full flag changed in shutdown");

  a_soft_rst_clears: assert property ( // [RL9]
    (ce && q.soft_link_reset_bit) |=> hif_in_reset && !q.hw_shutdown_enable
    && !q.soft_shutdown_bit) else $error("soft link reset left shutdown bits set");

  c_hw_shutdown: cover property (pd_fall && q.hw_shutdown_enable && ce);
  c_irq_raise:   cover property ($rose(irq));
  c_soft_sd:     cover property (q.soft_shutdown_bit && pd_rise);

endmodule : hif_gate_a20_shutdown

/* test/hif_host_model.sv */
// host side model: link clock, channel writes, reset and powerdown pins
`timescale 1ns/1ps
module hif_host_model (
  input  wire logic       clk_sys,
  output logic            lclk,
  output logic            lwr_valid,
  output logic [1:0]      lwr_chan,
  output logic            cmd_data_select,
  output logic [7:0]      lwr_data,
  output logic            lrst_n,
  output logic            lpcpd_n
);
  initial begin
    lclk = 1'b0;
    lwr_valid = 1'b0;
    lwr_chan = 2'h0;
    cmd_data_select = 1'b0;
    lwr_data = 8'h00;
    lrst_n = 1'b1;
    lpcpd_n = 1'b1;
  end

  // one write per frame: 200 ns of link clock high, then the clock stands still low
  task automatic host_write(input logic [1:0] chan, input logic is_cmd,
                            input logic [7:0] data);
    @(posedge clk_sys);
    lclk <= 1'b1;
    lwr_valid <= 1'b1;
    lwr_chan <= chan;
    cmd_data_select <= is_cmd;
    lwr_data <= data;
    repeat (4) @(posedge clk_sys);
    lclk <= 1'b0;
    // fields held past the synchronised fall so the sampling edge never races them
    repeat (6) @(posedge clk_sys);
    lwr_valid <= 1'b0;
    lwr_chan <= ~chan;
    cmd_data_select <= ~is_cmd;
    lwr_data <= ~data;
  endtask : host_write

  task automatic set_pd(input logic v);
    @(posedge clk_sys);
    lpcpd_n <= v;
    repeat (6) @(posedge clk_sys);
  endtask : set_pd

  task automatic set_rst(input logic v);
    @(posedge clk_sys);
    lrst_n <= v;
    repeat (6) @(posedge clk_sys);
  endtask : set_rst
endmodule : hif_host_model

/* test/lpc_gate_a20_and_shutdown_test.sv */
// self-checking bench for the gate a20 and shutdown block
`timescale 1ns/1ps
module lpc_gate_a20_and_shutdown_test;
  import hif_pkg::*;
  logic        clk_sys;
  logic        sys_rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err, lclk, lwr_valid, cmd_data_select, lrst_n, lpcpd_n;
  logic [1:0]  lwr_chan;
  logic [7:0]  lwr_data;
  logic        gate_a20_out, gate_a20_oe, pins_hiz, hif_in_reset, irq;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // entry: {chan, is_cmd, byte, gate after, full flag after}
  localparam logic [12:0] SEQ [0:16] = '{
    {2'h1, 1'b1, 8'hD1, 1'b1, 1'b0}, {2'h1, 1'b0, 8'h00, 1'b0, 1'b0},
    {2'h1, 1'b1, 8'hFF, 1'b0, 1'b0}, {2'h1, 1'b1, 8'hD1, 1'b0, 1'b0},
    {2'h1, 1'b0, 8'h02, 1'b1, 1'b0}, {2'h1, 1'b1, 8'h20, 1'b1, 1'b1},
    {2'h1, 1'b1, 8'hD1, 1'b1, 1'b0}, {2'h1, 1'b1, 8'hAA, 1'b1, 1'b1},
    {2'h1, 1'b0, 8'h00, 1'b1, 1'b1}, {2'h1, 1'b1, 8'hD1, 1'b1, 1'b0},
    {2'h1, 1'b1, 8'hD1, 1'b1, 1'b0}, {2'h1, 1'b0, 8'hFD, 1'b0, 1'b0},
    {2'h1, 1'b1, 8'hD1, 1'b0, 1'b0}, {2'h2, 1'b0, 8'h02, 1'b0, 1'b0},
    {2'h0, 1'b1, 8'hFF, 1'b0, 1'b0}, {2'h1, 1'b0, 8'h02, 1'b1, 1'b0},
    {2'h1, 1'b1, 8'hFF, 1'b1, 1'b0}};

  always #25 clk_sys = ~clk_sys;

  hif_gate_a20_shutdown dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lclk(lclk), .lwr_valid(lwr_valid), .lwr_chan(lwr_chan),
    .cmd_data_select(cmd_data_select), .lwr_data(lwr_data), .lrst_n(lrst_n),
    .lpcpd_n(lpcpd_n), .gate_a20_out(gate_a20_out), .gate_a20_oe(gate_a20_oe),
    .pins_hiz(pins_hiz), .hif_in_reset(hif_in_reset), .irq(irq));

  hif_host_model host (
    .clk_sys(clk_sys), .lclk(lclk), .lwr_valid(lwr_valid), .lwr_chan(lwr_chan),
    .cmd_data_select(cmd_data_select), .lwr_data(lwr_data), .lrst_n(lrst_n),
    .lpcpd_n(lpcpd_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // one apb transfer; waits for pready however long, only the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tick(20);
    sys_rst <= 1'b0;
    tick(10);
    check({gate_a20_out, gate_a20_oe, irq}, 3'b100);
    rdchk(OFS_CTRL0, 32'h0);
    rdchk(OFS_IRQ_MSK, 32'h0);
    rdchk(OFS_IRQ_STS, 32'h8);
    rdchk(12'h100, 32'h0);
    check(err, 1'b1);
    $display("test reset done");

    host.host_write(2'h1, 1'b1, 8'hD1);
    tick(2);
    check(gate_a20_out, 1'b1);
    rdchk(OFS_CTRL2, 32'h13);
    check(irq, 1'b0);
    apb(1'b1, OFS_IRQ_MSK, 32'h1);
    tick(2);
    check(irq, 1'b1);
    rdchk(OFS_IRQ_STS, 32'h1);
    tick(2);
    check(irq, 1'b0);
    rdchk(OFS_DATA1, 32'hD1);
    $display("test slow mode done");

    apb(1'b1, OFS_CTRL0, 32'h1);
    apb(1'b1, OFS_IRQ_MSK, 32'h2);
    check({gate_a20_out, gate_a20_oe}, 2'b11);
    foreach (SEQ[i]) begin
      host.host_write(SEQ[i][12:11], SEQ[i][10], SEQ[i][9:2]);
      tick(2);
      check(gate_a20_out, SEQ[i][1]);
      rdchk(OFS_CTRL2, {27'h0, 1'b1, 2'b00, SEQ[i][0], SEQ[i][1]});
      if (SEQ[i][0]) begin
        rdchk(OFS_DATA1, {24'h0, SEQ[i][9:2]});
      end
    end
    $display("test fast gate done");

    apb(1'b1, OFS_CTRL0, 32'h5);
    tick(3);
    check({hif_in_reset, pins_hiz, gate_a20_oe}, 3'b110);
    host.host_write(2'h1, 1'b1, 8'hD1);
    host.host_write(2'h1, 1'b0, 8'h00);
    tick(2);
    check(gate_a20_out, 1'b1);
    host.set_pd(1'b0);
    host.set_pd(1'b1);
    rdchk(OFS_CTRL0, 32'h5);
    host.set_pd(1'b0);
    apb(1'b1, OFS_CTRL0, 32'h7);
    tick(3);
    rdchk(OFS_CTRL0, 32'h3);
    rdchk(OFS_CTRL2, 32'h0D);
    // the hardware shutdown has cleared soft_shutdown_bit before the powerdown pin rises
    host.set_pd(1'b1);
    rdchk(OFS_CTRL0, 32'h1);
    check({hif_in_reset, pins_hiz, gate_a20_oe, irq}, 4'b0011);
    rdchk(OFS_IRQ_STS, 32'h7);
    tick(2);
    check(irq, 1'b0);
    apb(1'b1, OFS_CTRL0, 32'h3);
    host.set_pd(1'b0);
    check({pins_hiz, hif_in_reset, gate_a20_out}, 3'b111);
    host.set_pd(1'b1);
    $display("test shutdown done");

    host.host_write(2'h1, 1'b1, 8'hD1);
    host.host_write(2'h1, 1'b0, 8'h00);
    tick(2);
    check(gate_a20_out, 1'b0);
    apb(1'b1, OFS_CTRL0, 32'h7);
    host.set_rst(1'b0);
    check(gate_a20_out, 1'b1);
    host.set_rst(1'b1);
    tick(4);
    rdchk(OFS_CTRL0, 32'h1);
    $display("test link reset done");

    host.host_write(2'h1, 1'b1, 8'hD1);
    host.host_write(2'h1, 1'b0, 8'h00);
    check(gate_a20_out, 1'b0);
    apb(1'b1, OFS_CTRL0, 32'h9);
    tick(2);
    check({gate_a20_out, hif_in_reset}, 2'b11);
    rdchk(OFS_CTRL0, 32'h9);
    apb(1'b1, OFS_CTRL0, 32'h1);
    ce <= 1'b0;
    host.host_write(2'h1, 1'b1, 8'hD1);
    host.host_write(2'h1, 1'b0, 8'h00);
    ce <= 1'b1;
    tick(4);
    check(gate_a20_out, 1'b1);
    $display("test soft reset and freeze done");
    summarize();
  end
endmodule : lpc_gate_a20_and_shutdown_test
